/* File: common/ddr_burst_pkg.sv */
// shared constants and helpers for the burst memory port and its controller
`default_nettype none

package ddr_burst_pkg;

    // ------------------------------------------------------------------
    // data path geometry
    // ------------------------------------------------------------------
    localparam int WORD_W    = 18;
    localparam int ADDR_W    = 8;
    localparam int BURST_LEN = 2;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int MCLK_PERIOD_NS   = 40;
    localparam int LINK_PERIOD_NS   = 320;
    localparam int LINK_MAX_FREQ_MHZ = 550;
    localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
    // read latency counted in link half cycles (2.5 cycles and 1 cycle)
    localparam logic [2:0] LAT_LONG_HALF  = 3'h5;
    localparam logic [2:0] LAT_SHORT_HALF = 3'h2;

    // ------------------------------------------------------------------
    // reset values of the link pins and of the controller half period counter
    // ------------------------------------------------------------------
    localparam logic K_IDLE    = 1'b0;
    localparam logic KN_IDLE   = 1'b1;
    localparam logic LDN_IDLE  = 1'b1;
    localparam logic [1:0] HALF_RESET = 2'h3;

    function automatic logic rising(input logic now_v, input logic prev_v);
        return now_v & ~prev_v;
    endfunction

endpackage

`default_nettype wire

/* File: common/ddr_link_if.sv */
// link between the burst memory port and the memory controller
`default_nettype none

interface ddr_link_if #(
    parameter int WORD_W = ddr_burst_pkg::WORD_W,
    parameter int ADDR_W = ddr_burst_pkg::ADDR_W
);
    logic              k;
    logic              k_n;
    logic              ld_n;
    logic              rw;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] dq_ctl;
    logic              dq_ctl_oe;
    logic [WORD_W-1:0] dq_dev;
    logic              dq_dev_oe;
    logic [WORD_W-1:0] dq;
    logic              echo_timing_pair_p;
    logic              echo_timing_pair_n;
    logic              read_valid_flag;

    // shared data pins: whichever end enables its driver owns the wire, the device when both do
    assign dq = dq_dev_oe ? dq_dev : (dq_ctl_oe ? dq_ctl : '0);

    modport device (
        input  k, k_n, ld_n, rw, addr, dq,
        output dq_dev, dq_dev_oe, echo_timing_pair_p, echo_timing_pair_n, read_valid_flag
    );

    modport ctrl (
        output k, k_n, ld_n, rw, addr, dq_ctl, dq_ctl_oe,
        input  dq, echo_timing_pair_p, echo_timing_pair_n, read_valid_flag
    );
endinterface

`default_nettype wire

/* File: logic/burst_fifo.sv */
// request fifo with valid/ready on both sides
`default_nettype none

module burst_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = ddr_burst_pkg::FIFO_DEPTH
) (
    input  wire logic             mclk_i,
    input  wire logic             reset_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    import ddr_burst_pkg::*;

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [PW:0]      next_count;
    logic             push;
    logic             pop;

    assign push       = in_valid_i & in_ready_o;
    assign pop        = out_valid_o & out_ready_i;
    assign out_data_o = mem[rd_ptr];

    always_comb begin
        next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
        next_count  = (PW+1)'(count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
    end

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // ready and valid are registered so full and empty are exact
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            wr_ptr      <= next_wr_ptr;
            rd_ptr      <= next_rd_ptr;
            count       <= next_count;
            in_ready_o  <= (next_count != (PW+1)'(DEPTH));
            out_valid_o <= (next_count != '0);
        end
    end
endmodule

`default_nettype wire

/* File: logic/ddr_sram_device.sv */
// burst memory port: samples the link clocks, stores bursts, returns reads
// What this block does
// - addresses accepted on alternate primary clock rises
// - write words captured on both clock rises
// - read words launched on both clock rises
// - only rising edges of either clock matter
// - each address moves a two word burst
// - mode pin high: read after 2.5 cycles
// - mode pin low: read after one cycle
// - valid flag high while read data driven
// - echo clock pair travels with read data
// - one shared data bus, one direction
// - all inputs registered before use
// - all data outputs come from registers
// - writes complete internally, no strobe timing
// - controller keeps link clock within maximum
`default_nettype none

module ddr_sram_device #(
    parameter int WORD_W = ddr_burst_pkg::WORD_W,
    parameter int ADDR_W = ddr_burst_pkg::ADDR_W
) (
    input  wire logic   mclk_i,
    input  wire logic   reset_i,
    ddr_link_if.device  link,
    input  wire logic   latency_mode_pin_i,
    output logic        write_done_o,
    output logic        read_done_o
);
    import ddr_burst_pkg::*;

    typedef enum logic [2:0] {
        WR_IDLE  = 3'b001,
        WR_FIRST = 3'b010,
        WR_LAST  = 3'b100
    } wr_state_e;

    typedef enum logic [2:0] {
        OUT_IDLE  = 3'b001,
        OUT_FIRST = 3'b010,
        OUT_LAST  = 3'b100
    } out_state_e;

    localparam int PIN_W = 5 + ADDR_W + WORD_W;
    localparam logic [PIN_W-1:0] PIN_RESET = {K_IDLE, KN_IDLE, LDN_IDLE, {(PIN_W-3){1'b0}}};

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [PIN_W-1:0]  pin_meta;
    logic [PIN_W-1:0]  pin_sync;
    logic              k_prev;
    logic              kn_prev;
    logic              k_s;
    logic              kn_s;
    logic              ld_n_s;
    logic              rw_s;
    logic              lat_s;
    logic [ADDR_W-1:0] addr_s;
    logic [WORD_W-1:0] dq_s;
    logic              k_edge;
    logic              kn_edge;
    logic              any_edge;

    assign {k_s, kn_s, ld_n_s, rw_s, lat_s, addr_s, dq_s} = pin_sync;
    assign k_edge   = rising(k_s, k_prev);
    assign kn_edge  = rising(kn_s, kn_prev);
    assign any_edge = k_edge | kn_edge;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] mem [0:(2**ADDR_W)*BURST_LEN-1];
    logic              slot;
    wr_state_e         wr_state;
    logic [ADDR_W-1:0] wr_addr;
    logic [2:0]        rd_cnt [2];
    logic [ADDR_W-1:0] rd_addr [2];
    logic              rd_push;
    out_state_e        out_state;
    logic [ADDR_W-1:0] out_addr;
    logic [WORD_W-1:0] dq_out;
    logic              dq_oe;
    logic              valid;
    logic              echo_p;
    logic              echo_n;

    logic              next_slot;
    wr_state_e         next_wr_state;
    logic [ADDR_W-1:0] next_wr_addr;
    logic [2:0]        next_rd_cnt [2];
    logic [ADDR_W-1:0] next_rd_addr [2];
    logic              next_rd_push;
    out_state_e        next_out_state;
    logic [ADDR_W-1:0] next_out_addr;
    logic [WORD_W-1:0] next_dq_out;
    logic              next_dq_oe;
    logic              next_valid;
    logic              next_write_done;
    logic              next_read_done;
    logic              mem_we;
    logic [ADDR_W:0]   mem_idx;
    logic              launch;
    logic [ADDR_W-1:0] launch_addr;

    always_comb begin
        next_slot       = slot;
        next_wr_state   = wr_state;
        next_wr_addr    = wr_addr;
        next_rd_cnt     = rd_cnt;
        next_rd_addr    = rd_addr;
        next_rd_push    = rd_push;
        next_out_state  = out_state;
        next_out_addr   = out_addr;
        next_dq_out     = dq_out;
        next_dq_oe      = dq_oe;
        next_valid      = valid;
        next_write_done = 1'b0;
        next_read_done  = 1'b0;
        mem_we          = 1'b0;
        mem_idx         = {wr_addr, 1'b0};
        launch          = 1'b0;
        launch_addr     = rd_addr[0];
        if (any_edge) begin
            // two read slots so back to back reads overlap their latency
            for (int i = 0; i < 2; i++) begin
                if (rd_cnt[i] != 3'h0) begin
                    next_rd_cnt[i] = 3'(rd_cnt[i] - 3'h1);
                    if (rd_cnt[i] == 3'h1) begin
                        launch      = 1'b1;
                        launch_addr = rd_addr[i];
                    end
                end
            end
            case (wr_state)
                WR_FIRST: begin
                    mem_we        = 1'b1;
                    mem_idx       = {wr_addr, 1'b0};
                    next_wr_state = WR_LAST;
                end
                WR_LAST: begin
                    mem_we          = 1'b1;
                    mem_idx         = {wr_addr, 1'b1};
                    next_wr_state   = WR_IDLE;
                    next_write_done = 1'b1;
                end
                default: begin
                    next_wr_state = wr_state;
                end
            endcase
            if (launch) begin
                next_dq_out    = mem[{launch_addr, 1'b0}];
                next_dq_oe     = 1'b1;
                next_valid     = 1'b1;
                next_out_addr  = launch_addr;
                next_out_state = OUT_FIRST;
            end else begin
                case (out_state)
                    OUT_FIRST: begin
                        next_dq_out    = mem[{out_addr, 1'b1}];
                        next_out_state = OUT_LAST;
                    end
                    OUT_LAST: begin
                        next_dq_out    = '0;
                        next_dq_oe     = 1'b0;
                        next_valid     = 1'b0;
                        next_read_done = 1'b1;
                        next_out_state = OUT_IDLE;
                    end
                    default: begin
                        next_out_state = out_state;
                    end
                endcase
            end
            if (k_edge) begin
                next_slot = ~slot;
                if (!slot && !ld_n_s) begin
                    if (rw_s) begin
                        next_rd_cnt[rd_push]  = lat_s ? LAT_LONG_HALF : LAT_SHORT_HALF;
                        next_rd_addr[rd_push] = addr_s;
                        next_rd_push          = ~rd_push;
                    end else begin
                        next_wr_state = WR_FIRST;
                        next_wr_addr  = addr_s;
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (mem_we) begin
            mem[mem_idx] <= dq_s;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pin_meta     <= PIN_RESET;
            pin_sync     <= PIN_RESET;
            k_prev       <= K_IDLE;
            kn_prev      <= KN_IDLE;
            slot         <= 1'b0;
            wr_state     <= WR_IDLE;
            wr_addr      <= '0;
            rd_cnt       <= '{3'h0, 3'h0};
            rd_addr      <= '{'0, '0};
            rd_push      <= 1'b0;
            out_state    <= OUT_IDLE;
            out_addr     <= '0;
            dq_out       <= '0;
            dq_oe        <= 1'b0;
            valid        <= 1'b0;
            echo_p       <= K_IDLE;
            echo_n       <= KN_IDLE;
            write_done_o <= 1'b0;
            read_done_o  <= 1'b0;
        end else begin
            pin_meta     <= {link.k, link.k_n, link.ld_n, link.rw, latency_mode_pin_i,
                             link.addr, link.dq};
            pin_sync     <= pin_meta;
            k_prev       <= k_s;
            kn_prev      <= kn_s;
            slot         <= next_slot;
            wr_state     <= next_wr_state;
            wr_addr      <= next_wr_addr;
            rd_cnt       <= next_rd_cnt;
            rd_addr      <= next_rd_addr;
            rd_push      <= next_rd_push;
            out_state    <= next_out_state;
            out_addr     <= next_out_addr;
            dq_out       <= next_dq_out;
            dq_oe        <= next_dq_oe;
            valid        <= next_valid;
            echo_p       <= k_s;
            echo_n       <= kn_s;
            write_done_o <= next_write_done;
            read_done_o  <= next_read_done;
        end
    end

    // ------------------------------------------------------------------
    // link outputs
    // ------------------------------------------------------------------
    // outputs straight from registers
    assign link.dq_dev             = dq_out;
    assign link.dq_dev_oe          = dq_oe;
    assign link.read_valid_flag    = valid;
    assign link.echo_timing_pair_p = echo_p;
    assign link.echo_timing_pair_n = echo_n;
endmodule

`default_nettype wire

/* File: logic/ddr_sram_ctrl.sv */
// memory controller end: makes the link clocks and issues queued bursts
`default_nettype none

module ddr_sram_ctrl #(
    parameter int WORD_W = ddr_burst_pkg::WORD_W,
    parameter int ADDR_W = ddr_burst_pkg::ADDR_W,
    parameter int HALF   = ddr_burst_pkg::LINK_HALF_CYCLES,
    parameter int DEPTH  = ddr_burst_pkg::FIFO_DEPTH
) (
    input  wire logic              mclk_i,
    input  wire logic              reset_i,
    ddr_link_if.ctrl               link,
    input  wire logic              req_valid_i,
    output logic                   req_ready_o,
    input  wire logic              req_write_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic [2*WORD_W-1:0] req_data_i,
    output logic [WORD_W-1:0]      rd_word_o,
    output logic                   rd_word_valid_o
);
    import ddr_burst_pkg::*;

    typedef enum logic [2:0] {
        C_IDLE  = 3'b001,
        C_WRITE = 3'b010,
        C_READ  = 3'b100
    } ctrl_state_e;

    localparam int REQ_W = 1 + ADDR_W + 2 * WORD_W;
    localparam int DW    = $clog2(HALF);
    localparam int SYN_W = 3 + WORD_W;
    // echo pair idles as 0/1 so no false echo edge follows reset
    localparam logic [SYN_W-1:0] SYN_RESET = {K_IDLE, KN_IDLE, 1'b0, {WORD_W{1'b0}}};

    logic               fifo_valid;
    logic               fifo_pop;
    logic [REQ_W-1:0]   fifo_data;

    burst_fifo #(.WIDTH(REQ_W), .DEPTH(DEPTH)) req_fifo (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .in_valid_i  (req_valid_i),
        .in_ready_o  (req_ready_o),
        .in_data_i   ({req_write_i, req_addr_i, req_data_i}),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_data)
    );

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [SYN_W-1:0]    syn_meta;
    logic [SYN_W-1:0]    syn_sync;
    logic                ep_prev;
    logic                en_prev;
    logic [DW-1:0]       div;
    logic                k;
    logic                kn;
    logic [1:0]          half;
    ctrl_state_e         state;
    logic                ld_n;
    logic                rw;
    logic [ADDR_W-1:0]   addr;
    logic [2*WORD_W-1:0] wdata;
    logic [WORD_W-1:0]   dq;
    logic                oe;
    logic                words;

    logic [DW-1:0]       next_div;
    logic                next_k;
    logic [1:0]          next_half;
    ctrl_state_e         next_state;
    logic                next_ld_n;
    logic                next_rw;
    logic [ADDR_W-1:0]   next_addr;
    logic [2*WORD_W-1:0] next_wdata;
    logic [WORD_W-1:0]   next_dq;
    logic                next_oe;
    logic                next_words;
    logic [WORD_W-1:0]   next_rd_word;
    logic                next_rd_valid;
    logic                ep_s;
    logic                en_s;
    logic                valid_s;
    logic [WORD_W-1:0]   dq_s;
    logic                wrap;
    logic                mid;

    assign {ep_s, en_s, valid_s, dq_s} = syn_sync;
    assign wrap = (div == DW'(HALF - 1));
    // changes land mid half period, clear of the edges the device samples
    assign mid  = (div == DW'(HALF / 2 - 1));
    assign fifo_pop = mid && (half == 2'h3) && (state == C_IDLE) && fifo_valid;

    always_comb begin
        next_div      = wrap ? '0 : DW'(div + 1'b1);
        next_k        = wrap ? ~k : k;
        next_half     = wrap ? 2'(half + 2'h1) : half;
        next_state    = state;
        next_ld_n     = ld_n;
        next_rw       = rw;
        next_addr     = addr;
        next_wdata    = wdata;
        next_dq       = dq;
        next_oe       = oe;
        next_words    = words;
        next_rd_word  = rd_word_o;
        next_rd_valid = 1'b0;
        if (mid) begin
            case (half)
                2'h3: begin
                    if (fifo_pop) begin
                        next_ld_n  = 1'b0;
                        next_rw    = ~fifo_data[REQ_W-1];
                        next_addr  = fifo_data[REQ_W-2 -: ADDR_W];
                        next_wdata = fifo_data[2*WORD_W-1:0];
                        next_words = 1'b0;
                        next_state = fifo_data[REQ_W-1] ? C_WRITE : C_READ;
                    end
                end
                2'h0: begin
                    next_ld_n = LDN_IDLE;
                    if (state == C_WRITE) begin
                        next_dq = wdata[WORD_W-1:0];
                        next_oe = 1'b1;
                    end
                end
                2'h1: begin
                    if (state == C_WRITE) begin
                        next_dq = wdata[2*WORD_W-1:WORD_W];
                    end
                end
                2'h2: begin
                    if (state == C_WRITE) begin
                        next_oe    = 1'b0;
                        next_state = C_IDLE;
                    end
                end
                default: begin
                    next_ld_n = ld_n;
                end
            endcase
        end
        if ((rising(ep_s, ep_prev) || rising(en_s, en_prev)) && valid_s) begin
            next_rd_word  = dq_s;
            next_rd_valid = 1'b1;
            next_words    = 1'b1;
            if (words && state == C_READ) begin
                next_state = C_IDLE;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            syn_meta        <= SYN_RESET;
            syn_sync        <= SYN_RESET;
            ep_prev         <= K_IDLE;
            en_prev         <= KN_IDLE;
            div             <= '0;
            k               <= K_IDLE;
            kn              <= KN_IDLE;
            half            <= HALF_RESET;
            state           <= C_IDLE;
            ld_n            <= LDN_IDLE;
            rw              <= 1'b0;
            addr            <= '0;
            wdata           <= '0;
            dq              <= '0;
            oe              <= 1'b0;
            words           <= 1'b0;
            rd_word_o       <= '0;
            rd_word_valid_o <= 1'b0;
        end else begin
            syn_meta        <= {link.echo_timing_pair_p, link.echo_timing_pair_n,
                                link.read_valid_flag, link.dq};
            syn_sync        <= syn_meta;
            ep_prev         <= ep_s;
            en_prev         <= en_s;
            div             <= next_div;
            k               <= next_k;
            kn              <= ~next_k;
            half            <= next_half;
            state           <= next_state;
            ld_n            <= next_ld_n;
            rw              <= next_rw;
            addr            <= next_addr;
            wdata           <= next_wdata;
            dq              <= next_dq;
            oe              <= next_oe;
            words           <= next_words;
            rd_word_o       <= next_rd_word;
            rd_word_valid_o <= next_rd_valid;
        end
    end

    assign link.k         = k;
    // own flop so both link clocks leave registers on the same edge
    assign link.k_n       = kn;
    assign link.ld_n      = ld_n;
    assign link.rw        = rw;
    assign link.addr      = addr;
    assign link.dq_ctl    = dq;
    assign link.dq_ctl_oe = oe;
endmodule

`default_nettype wire

/* File: tb/ddr_link_sva.sv */
// link checker for the burst memory port and its controller
`default_nettype none
module ddr_link_sva #(
    parameter int WORD_W = ddr_burst_pkg::WORD_W
) (
    input wire logic              mclk_i,
    input wire logic              reset_i,
    input wire logic              k,
    input wire logic              k_n,
    input wire logic              ld_n,
    input wire logic              rw,
    input wire logic              dq_ctl_oe,
    input wire logic              dq_dev_oe,
    input wire logic [WORD_W-1:0] dq_dev,
    input wire logic              echo_timing_pair_p,
    input wire logic              echo_timing_pair_n,
    input wire logic              read_valid_flag,
    input wire logic              latency_mode_pin_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // link timing
    // ------------------------------------------------------------------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    kn_compl_a: assert property (k_n == ~k)
        else $error("link clock pair not complementary");
    link_rate_a: assert property ($changed(k) |=> $stable(k) [*3])
        else $error("link clock half period too short");
    bus_oneway_a: assert property (!(dq_ctl_oe && dq_dev_oe))
        else $error("both ends drive the data bus");
    valid_oe_a: assert property (read_valid_flag == dq_dev_oe)
        else $error("read valid flag disagrees with device drive");
    echo_pair_a: assert property (echo_timing_pair_n == ~echo_timing_pair_p)
        else $error("echo pair not complementary");
    word_echo_a: assert property (dq_dev_oe && $changed(dq_dev) |->
        $changed(echo_timing_pair_p)) else $error("read word moved without echo edge");
    addr_hold_a: assert property ($fell(ld_n) |-> !ld_n [*4])
        else $error("address strobe too short");
    wr_burst_a: assert property ($rose(dq_ctl_oe) |-> dq_ctl_oe [*8] ##1 !dq_ctl_oe)
        else $error("write burst not two words long");
    rd_burst_a: assert property ($rose(dq_dev_oe) |-> dq_dev_oe [*8] ##1 !dq_dev_oe)
        else $error("read burst not two words long");
    lat_short_a: assert property ($rose(k) && !ld_n && rw && !latency_mode_pin_i
        |-> ##[9:13] $rose(dq_dev_oe)) else $error("short read latency wrong");
    lat_long_a: assert property ($rose(k) && !ld_n && rw && latency_mode_pin_i
        |-> ##[21:25] $rose(dq_dev_oe)) else $error("long read latency wrong");
    cover property ($rose(dq_ctl_oe));
    cover property ($rose(dq_dev_oe) && latency_mode_pin_i);
    cover property ($rose(dq_dev_oe) && !latency_mode_pin_i);
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench joining the burst memory port and its controller
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ddr_burst_pkg::*;
    // ------------------------------------------------------------------
    // stimulus and collection
    // ------------------------------------------------------------------
    logic                mclk_i = 0, reset_i = 1, latency_mode_pin_i = 1;
    logic                req_valid = 0, req_write = 0, req_ready, rd_valid, wr_done, rd_done;
    logic [ADDR_W-1:0]   req_addr = '0;
    logic [2*WORD_W-1:0] req_data = '0;
    logic [WORD_W-1:0]   rd_word;
    logic [WORD_W-1:0]   got[$];
    int                  miscompares = 0, checks = 0, nwr = 0, nrd = 0;
    ddr_link_if ddr_link_if_i ();
    ddr_sram_device ddr_sram_device_i (.mclk_i, .reset_i, .link(ddr_link_if_i),
        .latency_mode_pin_i, .write_done_o(wr_done), .read_done_o(rd_done));
    ddr_sram_ctrl ddr_sram_ctrl_i (.mclk_i, .reset_i, .link(ddr_link_if_i),
        .req_valid_i(req_valid), .req_ready_o(req_ready), .req_write_i(req_write),
        .req_addr_i(req_addr), .req_data_i(req_data), .rd_word_o(rd_word),
        .rd_word_valid_o(rd_valid));
    ddr_link_sva ddr_link_sva_i (.mclk_i, .reset_i, .k(ddr_link_if_i.k),
        .k_n(ddr_link_if_i.k_n), .ld_n(ddr_link_if_i.ld_n), .rw(ddr_link_if_i.rw),
        .dq_ctl_oe(ddr_link_if_i.dq_ctl_oe), .dq_dev_oe(ddr_link_if_i.dq_dev_oe),
        .dq_dev(ddr_link_if_i.dq_dev), .echo_timing_pair_p(ddr_link_if_i.echo_timing_pair_p),
        .echo_timing_pair_n(ddr_link_if_i.echo_timing_pair_n),
        .read_valid_flag(ddr_link_if_i.read_valid_flag), .latency_mode_pin_i);
    initial forever #20 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        nwr += (wr_done === 1'b1);
        nrd += (rd_done === 1'b1);
        if (rd_valid === 1'b1) got.push_back(rd_word);
    end
    task summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [2*WORD_W-1:0] e, input logic [2*WORD_W-1:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    // valid stays up between calls so queued pushes go back to back
    task push(input logic w, input logic [ADDR_W-1:0] a, input logic [2*WORD_W-1:0] d);
        {req_valid, req_write, req_addr, req_data} = {1'b1, w, a, d};
        while (req_ready !== 1'b1) @(posedge mclk_i) #1;
        @(posedge mclk_i) #1;
    endtask
    task rd_chk(input logic [ADDR_W-1:0] a, input logic [2*WORD_W-1:0] e);
        int n;
        got = {};
        push(1'b0, a, '0);
        req_valid = 0;
        for (n = 0; n < 600 && got.size() < 2; n++) @(posedge mclk_i) #1;
        chk("read burst", e, {got[1], got[0]});
    endtask
    task t_reset;
        @(posedge mclk_i) #1;
        chk("idle link", 4'h9, {ddr_link_if_i.ld_n, ddr_link_if_i.dq_ctl_oe,
            ddr_link_if_i.dq_dev_oe, req_ready});
    endtask
    task t_burst(input logic m);
        logic [2*WORD_W-1:0] d;
        int                  w0;
        d = m ? 36'h9_8765_4321 : 36'h1_2345_6789;
        latency_mode_pin_i = m;
        repeat (4) @(posedge mclk_i) #1;
        w0 = nwr;
        push(1'b1, 8'h00, d);
        push(1'b1, 8'hff, ~d);
        rd_chk(8'hff, ~d);
        rd_chk(8'h00, d);
        chk("writes done", w0 + 2, nwr);
    endtask
    // twenty queued writes fill the queue until it refuses, and overwrite the first four addresses
    task t_fill;
        int i, low;
        low = 0;
        for (i = 0; i < 20; i++) begin
            low += (req_ready !== 1'b1);
            push(1'b1, ADDR_W'(i % 16), {WORD_W'(i + 7), WORD_W'(i)});
        end
        chk("queue refused", 1, low > 0);
        for (i = 0; i < 4; i++) rd_chk(ADDR_W'(i), {WORD_W'(i + 23), WORD_W'(i + 16)});
    endtask
    initial begin
        #(40 * 20000);
        miscompares++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge mclk_i);
        #1 reset_i = 0;
        t_reset();
        t_burst(1'b1);
        t_burst(1'b0);
        t_fill();
        repeat (20) @(posedge mclk_i) #1;
        chk("reads done", 8, nrd);
        summarize();
    end
endmodule
`default_nettype wire
